/* pkg/alert_judge_pkg.sv */
// Package: register map, mode codes and carriers for the alert judgment block
package alert_judge_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned NUM_CH       = 4;
  localparam int unsigned NUM_SLOT     = 4;
  localparam int unsigned DATA_W       = 16;
  localparam int unsigned ADDR_W       = 12;

  // ----------------------------------------------------------------
  // Buffer addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] CH1_STOP_BEHAVIOUR_ADDR    = 12'h118;
  localparam logic [11:0] CH2_STOP_BEHAVIOUR_ADDR    = 12'h148;
  localparam logic [11:0] CH3_STOP_BEHAVIOUR_ADDR    = 12'h178;
  localparam logic [11:0] CH4_STOP_BEHAVIOUR_ADDR    = 12'h1A8;
  localparam logic [11:0] ALERT_HYSTERESIS_BAND_ADDR = 12'h1E0;
  localparam logic [15:0] STOP_BEHAVIOUR_RESET       = 16'h0000;
  localparam logic [15:0] HYSTERESIS_BAND_RESET      = 16'h0000;

  // ----------------------------------------------------------------
  // Stop-mode values and status word layout
  // ----------------------------------------------------------------
  localparam logic [15:0] STOP_MODE_STOP    = 16'h0000;
  localparam logic [15:0] STOP_MODE_MONITOR = 16'h0001;
  localparam logic [15:0] STOP_MODE_ALERT   = 16'h0002;
  localparam int unsigned STATUS_ALERT_LSB  = 8;

  // ----------------------------------------------------------------
  // Alert mode codes
  // ----------------------------------------------------------------
  localparam logic [4:0] MODE_NONE          = 5'h00;
  localparam logic [4:0] MODE_UP_INPUT      = 5'h01;
  localparam logic [4:0] MODE_LO_INPUT      = 5'h02;
  localparam logic [4:0] MODE_UP_DEV        = 5'h03;
  localparam logic [4:0] MODE_LO_DEV        = 5'h04;
  localparam logic [4:0] MODE_UPLO_DEV      = 5'h05;
  localparam logic [4:0] MODE_IN_RANGE      = 5'h06;
  localparam logic [4:0] MODE_UP_INPUT_W    = 5'h07;
  localparam logic [4:0] MODE_LO_INPUT_W    = 5'h08;
  localparam logic [4:0] MODE_UP_DEV_W      = 5'h09;
  localparam logic [4:0] MODE_LO_DEV_W      = 5'h0A;
  localparam logic [4:0] MODE_UPLO_DEV_W    = 5'h0B;
  localparam logic [4:0] MODE_UP_DEV_RW     = 5'h0C;
  localparam logic [4:0] MODE_LO_DEV_RW     = 5'h0D;
  localparam logic [4:0] MODE_UPLO_DEV_RW   = 5'h0E;

  // Comparison kinds after decoding a mode code
  typedef enum logic [2:0] {
    KIND_NONE,
    KIND_UPPER,
    KIND_LOWER,
    KIND_BAND_OUT,
    KIND_BAND_IN
  } judge_kind_e;

  // One slot's configuration
  typedef struct packed {
    logic [4:0]        mode;
    logic signed [15:0] set_value;
  } slot_cfg_s;

  // Buffer write/read request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [15:0] wdata;
  } buf_req_s;

endpackage

/* logic/alert_slot_judge.sv */
// One alert slot: mode decode, threshold compare and dead-band hysteresis
`timescale 1ns/1ps
`default_nettype none
module alert_slot_judge
  import alert_judge_pkg::*;
(
  input  wire logic               mclk_i,
  input  wire logic               reset_n_i,
  input  wire logic               sample_i,
  input  wire slot_cfg_s          cfg_i,
  input  wire logic signed [15:0] measured_i,
  input  wire logic signed [15:0] target_i,
  input  wire logic [15:0]        band_i,
  output logic                    alert_o
);

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  judge_kind_e kind;
  logic        deviation;

  // Wait and re-wait variants judge like their plain forms here
  always_comb begin
    kind      = KIND_NONE;
    deviation = 1'b0;
    unique case (cfg_i.mode)
      MODE_UP_INPUT, MODE_UP_INPUT_W: kind = KIND_UPPER;
      MODE_LO_INPUT, MODE_LO_INPUT_W: kind = KIND_LOWER;
      MODE_UP_DEV, MODE_UP_DEV_W, MODE_UP_DEV_RW: begin
        kind      = KIND_UPPER;
        deviation = 1'b1;
      end
      MODE_LO_DEV, MODE_LO_DEV_W, MODE_LO_DEV_RW: begin
        kind      = KIND_LOWER;
        deviation = 1'b1;
      end
      MODE_UPLO_DEV, MODE_UPLO_DEV_W, MODE_UPLO_DEV_RW: begin
        kind      = KIND_BAND_OUT;
        deviation = 1'b1;
      end
      MODE_IN_RANGE: begin
        kind      = KIND_BAND_IN;
        deviation = 1'b1;
      end
      default: kind = KIND_NONE;
    endcase
  end

  // ----------------------------------------------------------------
  // Compare with hysteresis
  // ----------------------------------------------------------------
  // 18-bit math so deviation and threshold minus band cannot wrap
  logic signed [17:0] value;
  logic signed [17:0] thr;
  logic signed [17:0] mag;
  logic signed [17:0] band;
  logic               enter;
  logic               stay;

  always_comb begin
    value = deviation ? (18'(measured_i) - 18'(target_i)) : 18'(measured_i);
    thr   = 18'(cfg_i.set_value);
    band  = (band_i != 16'h0000) ? 18'(band_i) : 18'h00000;
    mag   = (value < 0) ? -value : value;
    enter = 1'b0;
    stay  = 1'b0;
    unique case (kind)
      KIND_UPPER: begin
        enter = value >= thr;
        stay  = value >= (thr - band);
      end
      KIND_LOWER: begin
        enter = value <= thr;
        stay  = value <= (thr + band);
      end
      KIND_BAND_OUT: begin
        enter = mag >= thr;
        stay  = mag >= (thr - band);
      end
      KIND_BAND_IN: begin
        enter = mag <= thr;
        stay  = mag <= (thr + band);
      end
      default: begin
        enter = 1'b0;
        stay  = 1'b0;
      end
    endcase
  end

  // Judged once per sampling pulse
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      alert_o <= 1'b0;
    end else if (sample_i) begin
      alert_o <= alert_o ? stay : enter;
    end
  end

endmodule
`default_nettype wire

/* logic/temperature_alert_judgment.sv */
// Top: per-channel alert slots, buffer registers and occurrence flags
`timescale 1ns/1ps
`default_nettype none
module temperature_alert_judgment
  import alert_judge_pkg::*;
#(
  parameter int unsigned CHANNELS = NUM_CH
)
(
  input  wire logic                       mclk_i,
  input  wire logic                       reset_n_i,
  input  wire logic                       sample_i,
  input  wire buf_req_s                   buf_req_i,
  input  wire slot_cfg_s [NUM_CH*NUM_SLOT-1:0] slot_cfg_i,
  input  wire logic [NUM_CH*16-1:0]       measured_temperature_i,
  input  wire logic [NUM_CH*16-1:0]       target_temperature_i,
  input  wire logic [NUM_CH-1:0]          run_i,
  output logic [15:0]                     buf_rdata_o,
  output logic                            buf_rvalid_o,
  output logic [NUM_CH-1:0]               channel_alert_occurred_flags_o,
  output logic [NUM_CH*16-1:0]            channel_status_words_o
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  // Address map only holds four stop-mode words
  if (CHANNELS != NUM_CH) begin : g_bad_ch
    $error("CHANNELS must equal four");
  end

  // ----------------------------------------------------------------
  // Buffer registers
  // ----------------------------------------------------------------
  logic [15:0] stop_mode_q [NUM_CH];
  logic [15:0] band_q;
  logic [11:0] stop_addr   [NUM_CH];

  assign stop_addr[0] = CH1_STOP_BEHAVIOUR_ADDR;
  assign stop_addr[1] = CH2_STOP_BEHAVIOUR_ADDR;
  assign stop_addr[2] = CH3_STOP_BEHAVIOUR_ADDR;
  assign stop_addr[3] = CH4_STOP_BEHAVIOUR_ADDR;

  // Separate stop-mode word per channel
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        stop_mode_q[c] <= STOP_BEHAVIOUR_RESET;
      end
    end else if (buf_req_i.wr) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (buf_req_i.addr == stop_addr[c]) begin
          stop_mode_q[c] <= buf_req_i.wdata;
        end
      end
    end
  end

  // Shared dead band
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      band_q <= HYSTERESIS_BAND_RESET;
    end else if (buf_req_i.wr && buf_req_i.addr == ALERT_HYSTERESIS_BAND_ADDR) begin
      band_q <= buf_req_i.wdata;
    end
  end

  // Read path; unmapped addresses read zero
  logic [15:0] rd_mux;

  always_comb begin
    rd_mux = 16'h0000;
    for (int c = 0; c < NUM_CH; c++) begin
      if (buf_req_i.addr == stop_addr[c]) begin
        rd_mux = stop_mode_q[c];
      end
    end
    if (buf_req_i.addr == ALERT_HYSTERESIS_BAND_ADDR) begin
      rd_mux = band_q;
    end
  end

  // Registered read data, one cycle after the read strobe
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      buf_rdata_o  <= 16'h0000;
      buf_rvalid_o <= 1'b0;
    end else begin
      buf_rvalid_o <= buf_req_i.rd;
      if (buf_req_i.rd) begin
        buf_rdata_o <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Slots and flags per channel
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0] run_q;
  logic [NUM_CH-1:0] flag_q;
  logic              sample_q;

  // Delayed sample pulse: the slot bits are judged by then, so the flag follows them
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      sample_q <= 1'b0;
    end else begin
      sample_q <= sample_i;
    end
  end

  // Previous run state for run-to-stop detection
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      run_q <= '0;
    end else begin
      run_q <= run_i;
    end
  end

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    logic [NUM_SLOT-1:0] slot_bits;
    logic                any_alert;
    logic                cause_gone;
    logic                to_stop;
    logic                stop_clears;

    // Four independent slots
    for (genvar s = 0; s < NUM_SLOT; s++) begin : g_slot
      alert_slot_judge u_slot (
        .mclk_i     (mclk_i),
        .reset_n_i  (reset_n_i),
        .sample_i   (sample_i),
        .cfg_i      (slot_cfg_i[c*NUM_SLOT+s]),
        .measured_i (measured_temperature_i[c*16 +: 16]),
        .target_i   (target_temperature_i[c*16 +: 16]),
        .band_i     (band_q),
        .alert_o    (slot_bits[s])
      );
    end

    assign any_alert   = |slot_bits;
    assign cause_gone  = !any_alert;
    assign to_stop     = run_q[c] && !run_i[c];
    // Modes 0 and 1 clear on stop; mode 2 and others keep the flag
    assign stop_clears = (stop_mode_q[c] == STOP_MODE_STOP) ||
                         (stop_mode_q[c] == STOP_MODE_MONITOR);

    // A newly sampled alert wins over a run-to-stop clear in the same cycle; an already set flag is cleared
    always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
        flag_q[c] <= 1'b0;
      end else if (cause_gone) begin
        flag_q[c] <= 1'b0;
      end else if (any_alert && !flag_q[c] && sample_q) begin
        flag_q[c] <= 1'b1;
      end else if (to_stop && stop_clears) begin
        flag_q[c] <= 1'b0;
      end
    end

    // Status word: alert bits in 8..11
    always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
        channel_status_words_o[c*16 +: 16] <= 16'h0000;
      end else begin
        channel_status_words_o[c*16 +: 16] <= 16'(slot_bits) << STATUS_ALERT_LSB;
      end
    end
  end

  assign channel_alert_occurred_flags_o = flag_q;

endmodule
`default_nettype wire

/* bench/master_station_model.sv */
// Master station model: word writes and reads into the buffer
`timescale 1ns/1ps
`default_nettype none
module master_station_model
  import alert_judge_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic [15:0] rdata_i,
  input  wire logic        rvalid_i,
  output var  buf_req_s    req_o
);
  // Idle after reset; a released bus shows inverted lines, not the last value
  initial req_o = '0;

  // Write strobe stands for one edge, then the bus is let go
  task automatic put(input logic [11:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    req_o <= '{1'b1, 1'b0, a, d};
    @(posedge mclk_i);
    req_o <= '{1'b0, 1'b0, ~a, ~d};
  endtask

  // Read word is taken while the answer strobe stands
  task automatic get(input logic [11:0] a, output logic [15:0] d, output logic v);
    @(posedge mclk_i);
    req_o <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge mclk_i);
    req_o <= '{1'b0, 1'b0, ~a, 16'hFFFF};
    @(negedge mclk_i);
    d = rdata_i;
    v = rvalid_i;
  endtask
endmodule
`default_nettype wire

/* bench/alert_judgment_asserts.sv */
// Checker: port-level properties of the alert judgment block
`timescale 1ns/1ps
`default_nettype none
module alert_judgment_asserts
  import alert_judge_pkg::*;
#(parameter int unsigned CHANNELS = NUM_CH)
(
  input wire logic             mclk_i,
  input wire logic             reset_n_i,
  input wire logic             sample_i,
  input wire buf_req_s         buf_req_i,
  input wire slot_cfg_s [15:0] slot_cfg_i,
  input wire logic [63:0]      measured_temperature_i,
  input wire logic [63:0]      target_temperature_i,
  input wire logic [3:0]       run_i,
  input wire logic [15:0]      buf_rdata_o,
  input wire logic             buf_rvalid_o,
  input wire logic [3:0]       channel_alert_occurred_flags_o,
  input wire logic [63:0]      channel_status_words_o
);
  // ----------------------------------------------------------------
  // Shadow of channel 1 stop word and dead band, channel 1 slot 1 view
  // ----------------------------------------------------------------
  logic [15:0]             stop_q;
  logic [15:0]             band_q;
  wire logic               flag0 = channel_alert_occurred_flags_o[0];
  wire logic [3:0]         st0 = channel_status_words_o[11:8];
  wire logic signed [17:0] pv0 = 18'(signed'(measured_temperature_i[15:0]));
  wire logic signed [17:0] thr0 = 18'(slot_cfg_i[0].set_value);
  wire logic signed [17:0] lo0 = thr0 - 18'(band_q);
  wire logic               up0 = slot_cfg_i[0].mode == MODE_UP_INPUT;

  // Follows the write stream so read data can be predicted
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      stop_q <= 16'h0000;
      band_q <= 16'h0000;
    end else if (buf_req_i.wr && buf_req_i.addr == CH1_STOP_BEHAVIOUR_ADDR) begin
      stop_q <= buf_req_i.wdata;
    end else if (buf_req_i.wr && buf_req_i.addr == ALERT_HYSTERESIS_BAND_ADDR) begin
      band_q <= buf_req_i.wdata;
    end
  end

  default clocking dc @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  chk_flag_has_bit: assert property (
    flag0 |-> |st0) else $error("flag without slot bit");
  chk_status_spare_zero: assert property (
    (channel_status_words_o & ~{4{16'h0F00}}) == 64'h0) else $error("spare status bit set");
  chk_flag_rise_cause: assert property (
    $rose(flag0) |-> $past(sample_i, 2)) else $error("flag rose without sample");
  chk_status_only_sample: assert property (
    !$past(sample_i, 2) |-> $stable(channel_status_words_o)) else $error("status moved unsampled");
  chk_upper_enter: assert property (
    up0 && sample_i && pv0 >= thr0 |-> ##2 st0[0]) else $error("upper alert not entered");
  chk_upper_leave: assert property (
    up0 && sample_i && pv0 < lo0 |-> ##2 !st0[0]) else $error("upper alert not left");
  chk_none_quiet: assert property (
    slot_cfg_i[0].mode == MODE_NONE && sample_i |-> ##2 !st0[0]) else $error("mode none alerted");
  chk_stop_clear: assert property (
    $fell(run_i[0]) && stop_q <= 16'h0001 |-> ##[1:2] !flag0) else $error("flag kept at stop");
  chk_alert_mode_keeps: assert property (
    stop_q >= 16'h0002 && flag0 && |st0 && !sample_i && !$past(sample_i) |=> flag0)
    else $error("flag dropped in alert mode");
  chk_read_answer: assert property (
    buf_req_i.rd && buf_req_i.addr == CH1_STOP_BEHAVIOUR_ADDR |=> buf_rvalid_o && buf_rdata_o == $past(stop_q))
    else $error("stop word read wrong");
endmodule

bind temperature_alert_judgment alert_judgment_asserts #(.CHANNELS(CHANNELS)) i_chk (
  .mclk_i(mclk_i), .reset_n_i(reset_n_i), .sample_i(sample_i), .buf_req_i(buf_req_i),
  .slot_cfg_i(slot_cfg_i), .measured_temperature_i(measured_temperature_i),
  .target_temperature_i(target_temperature_i), .run_i(run_i), .buf_rdata_o(buf_rdata_o),
  .buf_rvalid_o(buf_rvalid_o), .channel_alert_occurred_flags_o(channel_alert_occurred_flags_o),
  .channel_status_words_o(channel_status_words_o));
`default_nettype wire

/* bench/tb_temperature_alert_judgment.sv */
// Self-checking bench for the temperature alert judgment block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("Error %s exp %0h got %0h", nm, e, g); end end
module tb_temperature_alert_judgment;
  import alert_judge_pkg::*;
  logic             mclk_i = 1'b0;
  logic             reset_n_i = 1'b0;
  logic             sample_i = 1'b0;
  logic [3:0]       run = 4'hF;
  slot_cfg_s [15:0] cfg = '0;
  logic [63:0]      pv = '0;
  logic [63:0]      tv = '0;
  buf_req_s         req;
  logic [15:0]      rdata;
  logic             rvalid;
  logic [3:0]       flags;
  logic [63:0]      st;
  int               n_errors = 0;
  int               checks_done = 0;

  temperature_alert_judgment #(.CHANNELS(NUM_CH)) i_dut (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .sample_i(sample_i), .buf_req_i(req),
    .slot_cfg_i(cfg), .measured_temperature_i(pv), .target_temperature_i(tv), .run_i(run),
    .buf_rdata_o(rdata), .buf_rvalid_o(rvalid), .channel_alert_occurred_flags_o(flags),
    .channel_status_words_o(st));
  master_station_model i_host (.mclk_i(mclk_i), .rdata_i(rdata), .rvalid_i(rvalid), .req_o(req));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Inputs settle one edge before the sample so the judgment sees them
  task automatic jud(input int k, input logic [4:0] m, input logic [15:0] sv, x);
    @(posedge mclk_i);
    cfg[k] <= '{m, sv};
    pv[k/4*16 +: 16] <= x;
    @(posedge mclk_i);
    sample_i <= 1'b1;
    @(posedge mclk_i);
    sample_i <= 1'b0;
    @(posedge mclk_i);
    @(negedge mclk_i);
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    logic [11:0] ad [5] = '{CH1_STOP_BEHAVIOUR_ADDR, CH2_STOP_BEHAVIOUR_ADDR,
      CH3_STOP_BEHAVIOUR_ADDR, CH4_STOP_BEHAVIOUR_ADDR, ALERT_HYSTERESIS_BAND_ADDR};
    logic [15:0] d;
    logic        v;
    for (int i = 0; i < 5; i++) begin
      i_host.get(ad[i], d, v);
      `CHK("reset word", 16'h0000, d)
      i_host.put(ad[i], 16'hA5C0 + 16'(i));
      i_host.get(ad[i], d, v);
      `CHK("word", 16'hA5C0 + 16'(i), d)
      `CHK("rvalid", 1'b1, v)
      i_host.put(ad[i], 16'h0000);
    end
    i_host.get(12'h119, d, v);
    `CHK("unmapped", 16'h0000, d)
    $display("t_regs done");
  endtask

  // Band 5 holds the alert just above set minus band; band 0 drops it at once
  task automatic t_upper;
    logic [15:0] x [5] = '{16'h00C8, 16'h00C4, 16'h00C2, 16'h00C8, 16'h00C7};
    logic [4:0]  e = 5'h0B;
    i_host.put(ALERT_HYSTERESIS_BAND_ADDR, 16'h0005);
    for (int i = 0; i < 5; i++) begin
      if (i == 3) i_host.put(ALERT_HYSTERESIS_BAND_ADDR, 16'h0000);
      jud(0, MODE_UP_INPUT, 16'h00C8, x[i]);
      `CHK("slot1 bit", e[i], st[8])
      `CHK("ch1 flag", e[i], flags[0])
    end
    $display("t_upper done");
  endtask

  task automatic t_slots;
    logic [3:0] e;
    for (int n = 0; n < 4; n++) begin
      e[n] = 16'h0019 >= 16'h000A * 16'(n + 1);
      jud(4 + n, MODE_UP_INPUT, 16'h000A * 16'(n + 1), 16'h0019);
    end
    `CHK("ch2 bits", {4'h0, e, 8'h00}, st[31:16])
    `CHK("ch2 flag", 1'b1, flags[1])
    for (int n = 0; n < 4; n++) jud(4 + n, MODE_NONE, 16'h0000, 16'h0019);
    `CHK("ch2 clear", 16'h0000, st[31:16])
    `CHK("ch2 flag off", 1'b0, flags[1])
    $display("t_slots done");
  endtask

  // Deviation 100 against set 50: only upper input, upper deviation and upper/lower deviation kinds alert
  task automatic t_modes;
    logic [15:0] e = 16'h5AAA;
    for (int c = 0; c < 16; c++) begin
      jud(8, 5'(c), 16'h0032, 16'h0064);
      `CHK("mode bit", e[c], st[40])
      `CHK("mode flag", e[c], flags[2])
    end
    // Target equal to the measured value leaves no deviation
    @(posedge mclk_i);
    tv[32 +: 16] <= 16'h0064;
    jud(8, MODE_UP_DEV, 16'h0032, 16'h0064);
    `CHK("dev vs target", 1'b0, st[40])
    jud(8, MODE_UP_INPUT, 16'h0032, 16'h0064);
    `CHK("input ignores target", 1'b1, st[40])
    @(posedge mclk_i);
    tv[32 +: 16] <= 16'h0000;
    $display("t_modes done");
  endtask

  task automatic t_stop;
    for (int s = 0; s < 3; s++) begin
      i_host.put(CH1_STOP_BEHAVIOUR_ADDR, 16'(s));
      jud(0, MODE_UP_INPUT, 16'h00C8, 16'h00FA);
      @(posedge mclk_i);
      run[0] <= 1'b0;
      repeat (3) @(posedge mclk_i);
      @(negedge mclk_i);
      `CHK("flag at stop", s == 2, flags[0])
      @(posedge mclk_i);
      run[0] <= 1'b1;
      jud(0, MODE_UP_INPUT, 16'h00C8, 16'h0064);
      `CHK("flag cause gone", 1'b0, flags[0])
    end
    $display("t_stop done");
  endtask

  initial begin
    forever #50 mclk_i = ~mclk_i;
  end

  // Watchdog well beyond the few hundred cycles the scenarios need
  initial begin
    repeat (5000) @(posedge mclk_i);
    n_errors++;
    end_sim;
  end

  initial begin
    repeat (4) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    t_regs;
    t_upper;
    t_slots;
    t_modes;
    t_stop;
    end_sim;
  end
endmodule
`default_nettype wire
